// file: lpl_cfg.svh
// Register map, field positions, reset values and timing counts of the logic primitive block.
`ifndef LPL_CFG_SVH
`define LPL_CFG_SVH
`define LPL_ADDR_GATE_CFG  8'h00
`define LPL_ADDR_WAVE_CFG  8'h04
`define LPL_ADDR_HIGH_MS   8'h08
`define LPL_ADDR_LOW_MS    8'h0C
`define LPL_ADDR_STATUS    8'h10
`define LPL_ADDR_INPUTS    8'h14
`define LPL_GATE_FUNC_LSB  0
`define LPL_GATE_FUNC_MSB  2
`define LPL_GATE_CNT_LSB   4
`define LPL_GATE_CNT_MSB   8
`define LPL_GATE_CNT_MIN   5'h02
`define LPL_GATE_CNT_MAX   5'h10
`define LPL_GATE_CNT_RST   5'h02
`define LPL_GATE_FUNC_RST  3'h0
`define LPL_WAVE_EN_BIT    0
`define LPL_HIGH_MS_RST    16'h01F4
`define LPL_LOW_MS_RST     16'h01F4
`define LPL_CLK_NS         20
`define LPL_MS_NS          1000000
`define LPL_MS_CYCLES      (`LPL_MS_NS / `LPL_CLK_NS)
`endif

// file: lpl_pkg.sv
// Types shared by the logic primitive block.
package lpl_pkg;
  typedef enum logic [2:0] {
    LPL_AND,
    LPL_NAND,
    LPL_OR,
    LPL_NOR,
    LPL_XOR,
    LPL_XNOR
  } lpl_func_e;

  typedef enum logic [1:0] {
    LPL_WAVE_IDLE,
    LPL_WAVE_HIGH,
    LPL_WAVE_LOW
  } lpl_wave_e;

  typedef struct packed {
    logic [2:0]  func;
    logic [4:0]  count;
    logic        en_present;
    logic [15:0] high_period_ms;
    logic [15:0] low_period_ms;
  } lpl_cfg_s;

  typedef struct packed {
    logic [15:0] gate;
    logic        toggle;
    logic        set;
    logic        clear;
    logic        wave_en;
  } lpl_pins_s;
endpackage

// file: lpl_top.sv
// Logic primitive library: gate, toggle latch, set/reset latch, constants and square wave behind APB.
`timescale 1ns/10ps
`include "lpl_cfg.svh"

module lpl_top
  import lpl_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `LPL_MS_CYCLES
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Element inputs from pins.
  input  wire logic [15:0] gate_in,
  input  wire logic        toggle_in,
  input  wire logic        set_in,
  input  wire logic        clear_in,
  input  wire logic        wave_en_in,
  // Element outputs.
  output logic             gate_out,
  output logic             toggle_q,
  output logic             latch_q,
  output logic             const_high,
  output logic             const_low,
  output logic             wave_out
);

  // Evaluates the selected function over the enabled inputs.
  function automatic logic lpl_gate(input logic [2:0] func, input logic [15:0] in, input logic [4:0] count);
    logic [15:0] mask;
    logic [4:0]  n;
    logic        res;
    n = count;
    if (n < `LPL_GATE_CNT_MIN) begin
      n = `LPL_GATE_CNT_MIN;
    end
    if (n > `LPL_GATE_CNT_MAX) begin
      n = `LPL_GATE_CNT_MAX;
    end
    mask = 16'hFFFF >> (5'h10 - n);
    unique case (func)
      LPL_AND:  res = &(in | ~mask);
      LPL_NAND: res = ~&(in | ~mask);
      LPL_OR:   res = |(in & mask);
      LPL_NOR:  res = ~|(in & mask);
      LPL_XOR:  res = ^(in & mask);
      LPL_XNOR: res = ~^(in & mask);
      default:  res = &(in | ~mask);
    endcase
    return res;
  endfunction

  // Decodes the full byte address of an APB request.
  function automatic logic lpl_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    return addr == reg_addr;
  endfunction

  lpl_pins_s   pins_meta_reg;
  lpl_pins_s   pins_sync_reg;
  lpl_cfg_s    cfg_reg;
  lpl_cfg_s    cfg_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        gate_reg;
  logic        gate_next;
  logic        toggle_prev_reg;
  logic        toggle_prev_next;
  logic        toggle_reg;
  logic        toggle_next;
  logic        latch_reg;
  logic        latch_next;
  lpl_wave_e   wave_state_reg;
  lpl_wave_e   wave_state_next;
  logic [31:0] tick_cnt_reg;
  logic [31:0] tick_cnt_next;
  logic [15:0] ms_cnt_reg;
  logic [15:0] ms_cnt_next;
  logic        wave_reg;
  logic        wave_next;
  logic        wave_run;
  logic        ms_tick;
  logic        access;
  logic        mapped;

  // Two-flop synchroniser for every pin input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
    end else begin
      pins_meta_reg <= '{gate: gate_in, toggle: toggle_in, set: set_in, clear: clear_in, wave_en: wave_en_in};
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // APB register file; answers one cycle into the access phase.
  always_comb begin
    cfg_next     = cfg_reg;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    access       = psel && penable && !pready_reg;
    mapped       = lpl_hit(paddr, `LPL_ADDR_GATE_CFG) || lpl_hit(paddr, `LPL_ADDR_WAVE_CFG)
                || lpl_hit(paddr, `LPL_ADDR_HIGH_MS) || lpl_hit(paddr, `LPL_ADDR_LOW_MS)
                || lpl_hit(paddr, `LPL_ADDR_STATUS) || lpl_hit(paddr, `LPL_ADDR_INPUTS);
    if (access) begin
      pready_next  = 1'b1;
      pslverr_next = !mapped;
      prdata_next  = 32'h0000_0000;
      if (pwrite) begin
        if (lpl_hit(paddr, `LPL_ADDR_GATE_CFG)) begin
          cfg_next.func  = pwdata[`LPL_GATE_FUNC_MSB:`LPL_GATE_FUNC_LSB];
          cfg_next.count = pwdata[`LPL_GATE_CNT_MSB:`LPL_GATE_CNT_LSB];
        end
        if (lpl_hit(paddr, `LPL_ADDR_WAVE_CFG)) begin
          cfg_next.en_present = pwdata[`LPL_WAVE_EN_BIT];
        end
        if (lpl_hit(paddr, `LPL_ADDR_HIGH_MS)) begin
          cfg_next.high_period_ms = pwdata[15:0];
        end
        if (lpl_hit(paddr, `LPL_ADDR_LOW_MS)) begin
          cfg_next.low_period_ms = pwdata[15:0];
        end
      end else begin
        if (lpl_hit(paddr, `LPL_ADDR_GATE_CFG)) begin
          prdata_next[`LPL_GATE_FUNC_MSB:`LPL_GATE_FUNC_LSB] = cfg_reg.func;
          prdata_next[`LPL_GATE_CNT_MSB:`LPL_GATE_CNT_LSB]   = cfg_reg.count;
        end
        if (lpl_hit(paddr, `LPL_ADDR_WAVE_CFG)) begin
          prdata_next[`LPL_WAVE_EN_BIT] = cfg_reg.en_present;
        end
        if (lpl_hit(paddr, `LPL_ADDR_HIGH_MS)) begin
          prdata_next[15:0] = cfg_reg.high_period_ms;
        end
        if (lpl_hit(paddr, `LPL_ADDR_LOW_MS)) begin
          prdata_next[15:0] = cfg_reg.low_period_ms;
        end
        if (lpl_hit(paddr, `LPL_ADDR_STATUS)) begin
          prdata_next[5:0] = {1'b0, 1'b1, wave_reg, latch_reg, toggle_reg, gate_reg};
        end
        if (lpl_hit(paddr, `LPL_ADDR_INPUTS)) begin
          prdata_next[19:0] = {pins_sync_reg.wave_en, pins_sync_reg.clear, pins_sync_reg.set,
                               pins_sync_reg.toggle, pins_sync_reg.gate};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg     <= '{func: `LPL_GATE_FUNC_RST, count: `LPL_GATE_CNT_RST, en_present: 1'b1,
                       high_period_ms: `LPL_HIGH_MS_RST, low_period_ms: `LPL_LOW_MS_RST};
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      cfg_reg     <= cfg_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Gate and the two latches.
  always_comb begin
    gate_next        = lpl_gate(cfg_reg.func, pins_sync_reg.gate, cfg_reg.count);
    toggle_prev_next = pins_sync_reg.toggle;
    toggle_next      = toggle_reg;
    if (pins_sync_reg.toggle && !toggle_prev_reg) begin
      toggle_next = !toggle_reg;
    end
    latch_next = latch_reg;
    if (pins_sync_reg.clear) begin
      latch_next = 1'b0;
    end else if (pins_sync_reg.set) begin
      latch_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg        <= 1'b0;
      toggle_prev_reg <= 1'b0;
      toggle_reg      <= 1'b0;
      latch_reg       <= 1'b0;
    end else begin
      gate_reg        <= gate_next;
      toggle_prev_reg <= toggle_prev_next;
      toggle_reg      <= toggle_next;
      latch_reg       <= latch_next;
    end
  end

  // Square-wave generator with a millisecond prescaler.
  always_comb begin
    wave_run        = cfg_reg.en_present ? pins_sync_reg.wave_en : 1'b1;
    ms_tick         = tick_cnt_reg == CYC_PER_MS - 1;
    wave_state_next = wave_state_reg;
    tick_cnt_next   = ms_tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    ms_cnt_next     = ms_cnt_reg;
    if (!wave_run) begin
      wave_state_next = LPL_WAVE_IDLE;
      tick_cnt_next   = 32'h0000_0000;
      ms_cnt_next     = 16'h0000;
    end else begin
      unique case (wave_state_reg)
        LPL_WAVE_IDLE: begin
          wave_state_next = LPL_WAVE_HIGH;
          tick_cnt_next   = 32'h0000_0000;
          ms_cnt_next     = 16'h0000;
        end
        LPL_WAVE_HIGH: begin
          if (ms_tick) begin
            ms_cnt_next = ms_cnt_reg + 16'h0001;
            if (ms_cnt_next >= cfg_reg.high_period_ms) begin
              wave_state_next = LPL_WAVE_LOW;
              ms_cnt_next     = 16'h0000;
            end
          end
        end
        LPL_WAVE_LOW: begin
          if (ms_tick) begin
            ms_cnt_next = ms_cnt_reg + 16'h0001;
            if (ms_cnt_next >= cfg_reg.low_period_ms) begin
              wave_state_next = LPL_WAVE_HIGH;
              ms_cnt_next     = 16'h0000;
            end
          end
        end
        default: begin
          wave_state_next = LPL_WAVE_IDLE;
        end
      endcase
    end
    wave_next = wave_state_next == LPL_WAVE_HIGH;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_state_reg <= LPL_WAVE_IDLE;
      tick_cnt_reg   <= 32'h0000_0000;
      ms_cnt_reg     <= 16'h0000;
      wave_reg       <= 1'b0;
    end else begin
      wave_state_reg <= wave_state_next;
      tick_cnt_reg   <= tick_cnt_next;
      ms_cnt_reg     <= ms_cnt_next;
      wave_reg       <= wave_next;
    end
  end

  // Constant sources, registered so that they too come from flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      const_high <= 1'b1;
      const_low  <= 1'b0;
    end else begin
      const_high <= 1'b1;
      const_low  <= 1'b0;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign gate_out = gate_reg;
  assign toggle_q = toggle_reg;
  assign latch_q  = latch_reg;
  assign wave_out = wave_reg;

endmodule

// file: lpl_top_sva.sv
// Concurrent checks on the ports of the logic primitive block.
`timescale 1ns/10ps
`include "lpl_cfg.svh"
module lpl_top_sva
  import lpl_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `LPL_MS_CYCLES
) (
  // Clock, reset and bus.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Element pins.
  input wire logic        toggle_in,
  input wire logic        set_in,
  input wire logic        clear_in,
  input wire logic        wave_en_in,
  input wire logic        toggle_q,
  input wire logic        latch_q,
  input wire logic        const_high,
  input wire logic        const_low,
  input wire logic        wave_out
);
  logic en_pres_reg;
  logic en_pres_next;

  // Mirrors the enable-present bit from bus writes.
  always_comb begin
    en_pres_next = en_pres_reg;
    if (psel && penable && pwrite && pready && paddr == `LPL_ADDR_WAVE_CFG) begin
      en_pres_next = pwdata[`LPL_WAVE_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_pres_reg <= 1'b1;
    end else begin
      en_pres_reg <= en_pres_next;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_en_rise;
    $past(wave_en_in, 3) && !$past(wave_en_in, 4) && en_pres_reg && $past(en_pres_reg, 4);
  endsequence

  sequence s_full_high;
    wave_out [*4];
  endsequence

  a_const_high: assert property (const_high)
    else $error("constant high source low");
  a_const_low: assert property (!const_low)
    else $error("constant low source high");
  a_toggle_flip: assert property ($past(toggle_in, 3) && !$past(toggle_in, 4) |-> toggle_q != $past(toggle_q))
    else $error("toggle latch missed a rise");
  a_toggle_keep: assert property (toggle_q != $past(toggle_q) |-> $past(toggle_in, 3) && !$past(toggle_in, 4))
    else $error("toggle latch changed without a rise");
  a_latch_set: assert property ($past(set_in, 3) && !$past(clear_in, 3) |-> latch_q)
    else $error("latch not set");
  a_latch_clear: assert property ($past(clear_in, 3) |-> !latch_q)
    else $error("latch not cleared");
  a_latch_hold: assert property (!$past(set_in, 3) && !$past(clear_in, 3) |-> $stable(latch_q))
    else $error("latch did not hold");
  a_wave_gated: assert property (en_pres_reg && $past(en_pres_reg, 2) && !$past(wave_en_in, 3) |-> !wave_out)
    else $error("wave not gated off");
  a_wave_start: assert property (s_en_rise |-> s_full_high)
    else $error("wave did not start with a full high");
  a_reset_clear: assert property ($rose(presetn) |-> !toggle_q && !latch_q && !wave_out)
    else $error("outputs not cleared by reset");
endmodule

bind lpl_top lpl_top_sva #(.CYC_PER_MS(CYC_PER_MS)) chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .toggle_in, .set_in, .clear_in, .wave_en_in, .toggle_q, .latch_q, .const_high, .const_low,
  .wave_out);

// file: test_lpl_top.sv
// Self-checking bench for the logic primitive block.
`timescale 1ns/10ps
`include "lpl_cfg.svh"
module test_lpl_top
  import lpl_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, tg, st, cl, we;
  logic        pready, pslverr, gate_out, toggle_q, latch_q, c_hi, c_lo, wave_out;
  logic [7:0]  paddr;
  logic [15:0] gi;
  logic [31:0] pwdata, prdata, rd;
  int          err_count, n_checks;

  lpl_top #(.CYC_PER_MS(4)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .gate_in(gi), .toggle_in(tg), .set_in(st), .clear_in(cl), .wave_en_in(we),
    .gate_out, .toggle_q, .latch_q, .const_high(c_hi), .const_low(c_lo), .wave_out);

  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    chk(pslverr, e);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(0, a, 32'h0, e);
    chk(rd, exp);
  endtask

  // Counts the ones among the used inputs; a count outside 2 to 16 is clamped, codes 6 and 7 act as AND.
  function automatic logic eg(input int f, input int n, input logic [15:0] v);
    int ones;
    int used;
    ones = 0;
    used = (n < 2) ? 2 : ((n > 16) ? 16 : n);
    for (int b = 0; b < used; b++) begin
      ones += v[b];
    end
    case (lpl_func_e'(f[2:0]))
      LPL_NAND: return ones != used;
      LPL_OR:   return ones != 0;
      LPL_NOR:  return ones == 0;
      LPL_XOR:  return (ones % 2) == 1;
      LPL_XNOR: return (ones % 2) == 0;
      default:  return ones == used;
    endcase
  endfunction

  task automatic t_reset();
    apb(1, `LPL_ADDR_STATUS, 32'hFFFF_FFFF, 0);
    apb(1, 8'h18, 32'hFFFF_FFFF, 1);
    rdc(`LPL_ADDR_GATE_CFG, 32'h20, 0);
    rdc(`LPL_ADDR_WAVE_CFG, 32'h1, 0);
    rdc(`LPL_ADDR_HIGH_MS, 32'h1F4, 0);
    rdc(`LPL_ADDR_LOW_MS, 32'h1F4, 0);
    rdc(`LPL_ADDR_STATUS, 32'h10, 0);
    rdc(8'h18, 32'h0, 1);
    chk({c_hi, c_lo, toggle_q, latch_q, wave_out}, 32'h10);
  endtask

  task automatic t_gate();
    logic [15:0] pat [5] = '{16'h0000, 16'h0003, 16'hFFFC, 16'hFFFF, 16'h0007};
    int          cnt [5] = '{0, 2, 9, 16, 31};
    for (int f = 0; f < 8; f++) begin
      foreach (cnt[c]) begin
        apb(1, `LPL_ADDR_GATE_CFG, {23'h0, 5'(cnt[c]), 1'b0, 3'(f)}, 0);
        foreach (pat[i]) begin
          gi <= pat[i];
          repeat (5) @(posedge pclk);
          chk(gate_out, eg(f, cnt[c], pat[i]));
        end
      end
    end
  endtask

  task automatic t_latch();
    logic [2:0] s [7] = '{3'h5, 3'h1, 3'h6, 3'h0, 3'h5, 3'h2, 3'h0};
    for (int i = 0; i < 7; i++) begin
      {st, cl} <= s[i][2:1];
      tg <= i[0];
      repeat (5) @(posedge pclk);
      chk(latch_q, s[i][0]);
      chk(toggle_q, ((i + 1) / 2) % 2);
      rdc(`LPL_ADDR_INPUTS, {12'h0, we, cl, st, tg, gi}, 0);
    end
  endtask

  // Skips any partial high, then measures one high and one low run.
  task automatic meas(input int eh, input int el);
    int h, l, k;
    h = 0;
    l = 0;
    k = 0;
    while (wave_out === 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    while (wave_out !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    while (wave_out === 1'b1 && h < 50) begin
      @(posedge pclk);
      h++;
    end
    while (wave_out === 1'b0 && l < 50) begin
      @(posedge pclk);
      l++;
    end
    if (k >= 50 || h >= 50 || l >= 50) begin
      err_count++;
      test_done();
    end
    chk(h, eh);
    chk(l, el);
  endtask

  task automatic t_wave();
    apb(1, `LPL_ADDR_HIGH_MS, 32'h1, 0);
    apb(1, `LPL_ADDR_LOW_MS, 32'h2, 0);
    repeat (5) @(posedge pclk);
    chk(wave_out, 0);
    we <= 1;
    meas(4, 8);
    meas(4, 8);
    we <= 0;
    repeat (5) @(posedge pclk);
    chk(wave_out, 0);
    apb(1, `LPL_ADDR_WAVE_CFG, 32'h0, 0);
    meas(4, 8);
    apb(1, `LPL_ADDR_WAVE_CFG, 32'h1, 0);
    repeat (5) @(posedge pclk);
    chk(wave_out, 0);
  endtask

  initial begin
    err_count = 0;
    n_checks = 0;
    {presetn, psel, penable, pwrite, tg, st, cl, we} = '0;
    paddr = '0;
    pwdata = '0;
    gi = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_gate();
    t_latch();
    gi <= '0;
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_wave();
    test_done();
  end
endmodule
